/* rtl/swp_pkg.sv */
// Package with constants for the supervisor watchdog and power-fail block.
package swp_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ     = 250_000_000;
   localparam int unsigned WD_TIMEOUT_MS   = 1600;
   localparam int unsigned WD_TIMEOUT_CYC  = (CLK_FREQ_HZ / 1000) * WD_TIMEOUT_MS;
   localparam int unsigned WD_CNT_W        = 32;
   // ----------------------------------------------------------------
   // Levels and reset values
   // ----------------------------------------------------------------
   localparam logic        OUT_RELEASED    = 1'h1;
   localparam logic        OUT_ASSERTED    = 1'h0;
   localparam logic        KICK_RST_VAL    = 1'h0;
   localparam logic        JUMPER_OFF      = 1'h0;
   // ----------------------------------------------------------------
   // Watchdog states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SWP_WD_RUN   = 2'h1,
      SWP_WD_FAULT = 2'h2
   } swp_wd_state_t;
endpackage

/* rtl/swp_supervisor.sv */
// Watchdog with kick-toggle retrigger and power-fail warning for the host processor.
// What this block does
// - Missed kick while enabled drives the fault output low, asserting system reset.
// - Fault output stays low after a timeout until the kick input toggles.
// - Fault reaches reset only when the watchdog enable jumper is fitted.
// - Watchdog enable jumper defaults to off, so the watchdog is disabled.
// - Power-fail sense below 1.3 V drives the power-fail output low.
// - Power-fail output reaches the interrupt line only with its jumper fitted.
`timescale 1ns/1ps
module swp_supervisor #(
   parameter int unsigned TIMEOUT_CYC = swp_pkg::WD_TIMEOUT_CYC
) (
   input  wire logic CORE_CLK,
   input  wire logic RST,
   input  wire logic WD_KICK_INPUT,
   input  wire logic WATCHDOG_ENABLE_JUMPER,
   input  wire logic POWER_FAIL_SENSE_LOW,
   input  wire logic POWER_FAIL_ENABLE_JUMPER,
   output logic      WD_FAULT_OUTPUT_N,
   output logic      SYS_RESET_N,
   output logic      POWER_FAIL_OUTPUT_N,
   output logic      NMI_N
);

   // ----------------------------------------------------------------
   // Kick edge detection
   // ----------------------------------------------------------------
   logic                         kick_prev_r;
   logic                         kick_edge;
   logic [swp_pkg::WD_CNT_W-1:0] cnt_r;
   logic                         wd_en_r;
   swp_pkg::swp_wd_state_t       state_r;
   logic                         timeout;

   assign kick_edge = WD_KICK_INPUT != kick_prev_r;
   assign timeout   = cnt_r >= swp_pkg::WD_CNT_W'(TIMEOUT_CYC - 1);

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         kick_prev_r <= swp_pkg::KICK_RST_VAL;
      end else begin
         kick_prev_r <= WD_KICK_INPUT;
      end
   end

   // ----------------------------------------------------------------
   // Jumper register
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         wd_en_r <= swp_pkg::JUMPER_OFF;
      end else begin
         wd_en_r <= WATCHDOG_ENABLE_JUMPER;
      end
   end

   // ----------------------------------------------------------------
   // Timeout counter
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         cnt_r <= '0;
      end else if (kick_edge || !wd_en_r || state_r == swp_pkg::SWP_WD_FAULT) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + swp_pkg::WD_CNT_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Watchdog state machine
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state_r <= swp_pkg::SWP_WD_RUN;
      end else begin
         case (state_r)
            swp_pkg::SWP_WD_RUN: begin
               if (wd_en_r && !kick_edge && timeout) begin
                  state_r <= swp_pkg::SWP_WD_FAULT;
               end
            end
            swp_pkg::SWP_WD_FAULT: begin
               if (kick_edge) begin
                  state_r <= swp_pkg::SWP_WD_RUN;
               end
            end
            default: begin
               state_r <= swp_pkg::SWP_WD_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         WD_FAULT_OUTPUT_N <= swp_pkg::OUT_RELEASED;
         SYS_RESET_N       <= swp_pkg::OUT_RELEASED;
      end else begin
         WD_FAULT_OUTPUT_N <= (state_r == swp_pkg::SWP_WD_FAULT) ? swp_pkg::OUT_ASSERTED
                                                                 : swp_pkg::OUT_RELEASED;
         SYS_RESET_N       <= (state_r == swp_pkg::SWP_WD_FAULT && wd_en_r) ? swp_pkg::OUT_ASSERTED
                                                                            : swp_pkg::OUT_RELEASED;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         POWER_FAIL_OUTPUT_N <= swp_pkg::OUT_RELEASED;
         NMI_N               <= swp_pkg::OUT_RELEASED;
      end else begin
         POWER_FAIL_OUTPUT_N <= POWER_FAIL_SENSE_LOW ? swp_pkg::OUT_ASSERTED : swp_pkg::OUT_RELEASED;
         NMI_N <= (POWER_FAIL_SENSE_LOW && POWER_FAIL_ENABLE_JUMPER) ? swp_pkg::OUT_ASSERTED
                                                                     : swp_pkg::OUT_RELEASED;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_fault_on_timeout: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (state_r == swp_pkg::SWP_WD_RUN && wd_en_r && !kick_edge && timeout) |=> ##1 !WD_FAULT_OUTPUT_N)
      else $error("Fault output not asserted after timeout.");

   a_fault_held_low: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (state_r == swp_pkg::SWP_WD_FAULT && !kick_edge) |=> ##1 !WD_FAULT_OUTPUT_N)
      else $error("Fault output released without a kick transition.");

   a_fault_release: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (state_r == swp_pkg::SWP_WD_FAULT && kick_edge) |=> ##1 WD_FAULT_OUTPUT_N)
      else $error("Fault output not released after kick transition.");

   a_reset_gated: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      !SYS_RESET_N |-> ($past(wd_en_r) && !WD_FAULT_OUTPUT_N))
      else $error("System reset asserted without enabled watchdog fault.");

   a_kick_restart: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      kick_edge |=> cnt_r == '0)
      else $error("Kick transition did not restart the counter.");

   a_disabled_quiet: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      !wd_en_r |=> SYS_RESET_N)
      else $error("Reset asserted while watchdog disabled.");

   a_pf_output: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      POWER_FAIL_SENSE_LOW |=> !POWER_FAIL_OUTPUT_N)
      else $error("Power-fail output not asserted on low sense.");

   a_nmi_gated: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      !NMI_N |-> ($past(POWER_FAIL_ENABLE_JUMPER) && !POWER_FAIL_OUTPUT_N))
      else $error("Interrupt asserted without jumper or power fail.");

   a_pf_release: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      !POWER_FAIL_SENSE_LOW |=> POWER_FAIL_OUTPUT_N)
      else $error("Power-fail output held low with sense above threshold.");

   a_nmi_follow: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (POWER_FAIL_SENSE_LOW && POWER_FAIL_ENABLE_JUMPER) |=> !NMI_N)
      else $error("Interrupt not asserted on power fail with jumper fitted.");

   a_nmi_quiet: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      !POWER_FAIL_ENABLE_JUMPER |=> NMI_N)
      else $error("Interrupt asserted with jumper removed.");

   a_reset_routed: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (!WD_FAULT_OUTPUT_N && $past(wd_en_r)) |-> !SYS_RESET_N)
      else $error("Enabled watchdog fault did not reach system reset.");

   a_unrouted_quiet: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (!WD_FAULT_OUTPUT_N && !$past(wd_en_r)) |-> SYS_RESET_N)
      else $error("Watchdog fault reached reset with jumper removed.");

   a_reset_needs_fault: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      WD_FAULT_OUTPUT_N |-> SYS_RESET_N)
      else $error("System reset asserted without a watchdog fault.");

   a_count_bound: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      cnt_r <= swp_pkg::WD_CNT_W'(TIMEOUT_CYC))
      else $error("Timeout counter ran past the timeout period.");

   a_count_idle: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      !wd_en_r |=> cnt_r == '0)
      else $error("Timeout counter advanced while watchdog disabled.");

   a_kick_holdoff: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      kick_edge |=> ##1 WD_FAULT_OUTPUT_N)
      else $error("Fault output low right after a kick transition.");

   a_fault_needs_en: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      $fell(WD_FAULT_OUTPUT_N) |-> $past(wd_en_r, 2))
      else $error("Fault output asserted while watchdog disabled.");

   // ----------------------------------------------------------------
   // Coverage
   // ----------------------------------------------------------------

   c_timeout:  cover property (@(posedge CORE_CLK) disable iff (RST) $fell(SYS_RESET_N));
   c_recover:  cover property (@(posedge CORE_CLK) disable iff (RST) $rose(WD_FAULT_OUTPUT_N));
   c_nmi:      cover property (@(posedge CORE_CLK) disable iff (RST) $fell(NMI_N));
   c_pf_clear: cover property (@(posedge CORE_CLK) disable iff (RST) $rose(POWER_FAIL_OUTPUT_N));
   c_unrouted: cover property (@(posedge CORE_CLK) disable iff (RST) !WD_FAULT_OUTPUT_N && SYS_RESET_N);

endmodule // swp_supervisor

/* verification/swp_host.sv */
// Host model that toggles the kick line at a chosen spacing.
`timescale 1ns/1ps
module swp_host (
   input  wire logic       clk,
   input  wire logic       run,
   input  wire logic [7:0] gap,
   output logic            kick
);
   int   cnt   = 0;
   logic level = 1'b0;
   assign kick = level;
   always @(negedge clk) begin
      if (run && cnt >= gap) begin
         level <= ~level;
         cnt   <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // swp_host

/* verification/tb_top.sv */
// Self-checking bench for the supervisor watchdog and power-fail block.
`timescale 1ns/1ps
module tb_top;
   localparam int T = 20;
   logic       clk, rst, en_j, pf_s, pf_j, run;
   logic [7:0] gap, seed;
   logic       kick, fault_n, rst_n, pfail_n, nmi_n;
   int         fail_count = 0;
   int         checks = 0;
   int         n;
   int         m_quiet = 0;
   bit         m_prev = 1'b0;
   bit         m_en = 1'b0;
   bit         m_trip = 1'b0;
   bit         m_kick;
   logic [3:0] exp_q[$];
   logic [3:0] exp_v;
   swp_host u_swp_host (.clk(clk), .run(run), .gap(gap), .kick(kick));
   swp_supervisor #(.TIMEOUT_CYC(T)) u_swp_supervisor (
      .CORE_CLK(clk), .RST(rst), .WD_KICK_INPUT(kick), .WATCHDOG_ENABLE_JUMPER(en_j),
      .POWER_FAIL_SENSE_LOW(pf_s), .POWER_FAIL_ENABLE_JUMPER(pf_j), .WD_FAULT_OUTPUT_N(fault_n),
      .SYS_RESET_N(rst_n), .POWER_FAIL_OUTPUT_N(pfail_n), .NMI_N(nmi_n));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input string name, input logic seen, input logic exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         m_quiet = 0;
         m_prev  = 1'b0;
         m_en    = 1'b0;
         m_trip  = 1'b0;
         exp_q.delete();
      end else begin
         exp_q.push_back({~m_trip, ~(m_trip & m_en), ~pf_s, ~(pf_s & pf_j)});
         m_kick  = (kick !== m_prev);
         m_prev  = kick;
         m_quiet = (m_trip || m_kick || !m_en) ? 0 : m_quiet + 1;
         m_trip  = m_trip ? !m_kick : (m_quiet >= T);
         m_en    = en_j;
      end
   end
   always @(negedge clk) begin
      if (exp_q.size() > 0) begin
         exp_v = exp_q.pop_front();
         chk("model_fault", fault_n, exp_v[3]);
         chk("model_reset", rst_n, exp_v[2]);
         chk("model_pf", pfail_n, exp_v[1]);
         chk("model_nmi", nmi_n, exp_v[0]);
      end
   end
   initial begin
      #20000;
      fail_count++;
      wrap_up();
   end
   initial begin
      rst  = 1'b1;
      en_j = 1'b0;
      pf_s = 1'b0;
      pf_j = 1'b0;
      run  = 1'b0;
      gap  = 8'h00;
      seed = 8'h30;
      cyc(16);
      rst <= 1'b0;
      begin : scenarios
         cyc(3 * T);
         chk("fault_default", fault_n, 1'b1);
         chk("reset_default", rst_n, 1'b1);
         en_j <= 1'b1;
         run  <= 1'b1;
         repeat (120) begin
            seed = lfsr(seed);
            gap  <= seed % 8'h0E;
            pf_s <= seed[0];
            pf_j <= seed[6];
            cyc(1);
            chk("reset_kicked", rst_n, 1'b1);
         end
         gap <= 8'h00;
         cyc(4);
         run <= 1'b0;
         n = 0;
         while (rst_n === 1'b1 && n < 3 * T) begin
            cyc(1);
            n++;
         end
         if (n >= 3 * T) begin
            fail_count++;
            disable scenarios;
         end
         chk("timeout_late", n >= T + 2, 1'b1);
         chk("timeout_early", n <= T + 2, 1'b1);
         chk("fault_low", fault_n, 1'b0);
         cyc(2 * T);
         chk("fault_held", fault_n, 1'b0);
         en_j <= 1'b0;
         cyc(4);
         chk("reset_unrouted", rst_n, 1'b1);
         chk("fault_kept", fault_n, 1'b0);
         run <= 1'b1;
         gap <= 8'h03;
         cyc(6);
         chk("fault_freed", fault_n, 1'b1);
         run <= 1'b0;
         cyc(3 * T);
         chk("fault_disabled", fault_n, 1'b1);
         for (int i = 0; i < 4; i++) begin
            pf_s <= i[0];
            pf_j <= i[1];
            cyc(3);
            chk("pf_out", pfail_n, ~i[0]);
            chk("nmi", nmi_n, ~(i[0] & i[1]));
         end
      end
      wrap_up();
   end
endmodule // tb_top
